// >>> pof_output_stage.sv
// Output swap and software force stage with an Avalon-MM register slave.
`default_nettype none
module pof_output_stage
  import pof_pkg::*;
#(
  parameter int NUM_CHANNELS = pof_pkg::CHANNELS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic swap_sync_event,
  input wire logic force_sync_event,
  input wire logic [NUM_CHANNELS-1:0] raw_channel_out,
  output logic [NUM_CHANNELS-1:0] channel_pin_out
);
  import pof_pkg::*;

  // Data path: raw channel levels pass the pair swap, then the software force, then one
  // register stage before the pins. A change of the raw levels therefore shows on the
  // pins one clock later, and a change of an active control copy does as well.
  //
  // Control path: swap and force writes land in buffers. Each active copy either follows its
  // buffer on every clock or, when its sync select is set, only at its own sync event
  // pulse. A write that lands in the same cycle as a load is picked up by the next load,
  // never lost and never half applied.
  //
  // Bus timing: every access takes two cycles. The first cycle always waits; read data is
  // captured there and write data is stored at the second edge, where waitrequest is low.
  // A master that withdraws its request while waitrequest is high leaves the swap, force and
  // sync registers untouched; a withdrawn read has already loaded the read data register.
  //
  // Limitation: the force fields are eight bits wide, so only the first eight channels can
  // be forced when the channel count is raised.

  // Channels come in complementary pairs, so there are half as many pairs as channels.
  localparam int NP = NUM_CHANNELS / 2;

  // Register bus handshake.
  logic bus_request;
  logic wr_take;
  logic rd_take;
  logic sel_swap;
  logic sel_force;
  logic sel_sync;
  logic wr_swap;
  logic wr_force;
  logic wr_sync;
  logic answered_reg;
  logic answered_next;
  logic [31:0] readdata_reg;
  logic [31:0] readdata_next;

  // Write data split into the fields that each register keeps.
  logic [NP-1:0] swap_field;
  pof_force_t force_field;
  logic inversion_field;
  logic force_sync_field;

  // Read views of the three registers.
  logic [31:0] swap_word;
  logic [31:0] force_word;
  logic [31:0] sync_word;

  // Pair-swap enables: software fills the buffer, the output path uses the active copy.
  logic [NP-1:0] swap_buffer_reg;
  logic [NP-1:0] swap_buffer_next;
  logic [NP-1:0] swap_active_reg;
  logic [NP-1:0] swap_active_next;
  logic swap_load;

  // Software force fields, buffered in the same way.
  pof_force_t force_buffer_reg;
  pof_force_t force_buffer_next;
  pof_force_t force_active_reg;
  pof_force_t force_active_next;
  logic force_load;

  // Selects that decide whether the active copies follow their buffers on every clock.
  logic inversion_sync_select_reg;
  logic inversion_sync_select_next;
  logic force_sync_select_reg;
  logic force_sync_select_next;

  // Output path.
  logic [NUM_CHANNELS-1:0] swapped;
  logic [NUM_CHANNELS-1:0] forced;
  logic [NUM_CHANNELS-1:0] pin_reg;
  logic [NUM_CHANNELS-1:0] pin_next;

  // Every access waits exactly one cycle; the fixed latency keeps read data registered.
  assign bus_request = avs_read | avs_write;
  assign avs_waitrequest = bus_request & ~answered_reg;

  // A write lands only at the edge where waitrequest is low, where the master sees it done.
  assign wr_take = avs_write & answered_reg;

  // Read data is captured during the wait cycle, so it already stands when waitrequest drops.
  assign rd_take = avs_read & ~answered_reg;

  assign sel_swap = (avs_address == OFS_PAIR_SWAP_CONTROL);
  assign sel_force = (avs_address == OFS_SOFTWARE_OUTPUT_FORCE);
  assign sel_sync = (avs_address == OFS_SYNC_CONFIGURATION);

  // Writes to unmapped addresses match no strobe and are dropped.
  assign wr_swap = wr_take & sel_swap;
  assign wr_force = wr_take & sel_force;
  assign wr_sync = wr_take & sel_sync;

  assign swap_field = avs_writedata[NP-1:0];
  assign force_field = {avs_writedata[FORCE_VALUE_LSB +: 8], avs_writedata[FORCE_ENABLE_LSB +: 8]};
  assign inversion_field = avs_writedata[INVERSION_SYNC_BIT];
  assign force_sync_field = avs_writedata[FORCE_SYNC_BIT];

  assign avs_readdata = readdata_reg;
  assign channel_pin_out = pin_reg;

  always_comb begin
    answered_next = bus_request & ~answered_reg;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      answered_reg <= 1'b0;
    end else begin
      answered_reg <= answered_next;
    end
  end

  // Reads return the active copies, so software sees what the pins really use.
  always_comb begin
    swap_word = UNMAPPED_READ_VALUE;
    swap_word[NP-1:0] = swap_active_reg;
  end

  always_comb begin
    force_word = UNMAPPED_READ_VALUE;
    force_word[FORCE_VALUE_LSB +: 8] = force_active_reg.value;
    force_word[FORCE_ENABLE_LSB +: 8] = force_active_reg.enable;
  end

  always_comb begin
    sync_word = UNMAPPED_READ_VALUE;
    sync_word[INVERSION_SYNC_BIT] = inversion_sync_select_reg;
    sync_word[FORCE_SYNC_BIT] = force_sync_select_reg;
  end

  // Unmapped addresses read as zero.
  always_comb begin
    readdata_next = readdata_reg;
    if (rd_take) begin
      unique case (avs_address)
        OFS_PAIR_SWAP_CONTROL: begin
          readdata_next = swap_word;
        end
        OFS_SOFTWARE_OUTPUT_FORCE: begin
          readdata_next = force_word;
        end
        OFS_SYNC_CONFIGURATION: begin
          readdata_next = sync_word;
        end
        default: begin
          readdata_next = UNMAPPED_READ_VALUE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readdata_reg <= 32'h0000_0000;
    end else begin
      readdata_reg <= readdata_next;
    end
  end

  // Loading every clock is the default; the select defers it to the PWM sync event instead.
  assign swap_load = ~inversion_sync_select_reg | swap_sync_event;

  always_comb begin
    swap_buffer_next = swap_buffer_reg;
    swap_active_next = swap_active_reg;
    if (wr_swap) begin
      swap_buffer_next = swap_field;
    end
    if (swap_load) begin
      swap_active_next = swap_buffer_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      swap_buffer_reg <= RESET_PAIR_SWAP_CONTROL[NP-1:0];
      swap_active_reg <= RESET_PAIR_SWAP_CONTROL[NP-1:0];
    end else begin
      swap_buffer_reg <= swap_buffer_next;
      swap_active_reg <= swap_active_next;
    end
  end

  // The force fields load the same way under their own select and event.
  assign force_load = ~force_sync_select_reg | force_sync_event;

  always_comb begin
    force_buffer_next = force_buffer_reg;
    force_active_next = force_active_reg;
    if (wr_force) begin
      force_buffer_next = force_field;
    end
    if (force_load) begin
      force_active_next = force_buffer_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      force_buffer_reg <= RESET_SOFTWARE_OUTPUT_FORCE[15:0];
      force_active_reg <= RESET_SOFTWARE_OUTPUT_FORCE[15:0];
    end else begin
      force_buffer_reg <= force_buffer_next;
      force_active_reg <= force_active_next;
    end
  end

  // The sync selects take effect at once; they have no buffer of their own.
  always_comb begin
    inversion_sync_select_next = inversion_sync_select_reg;
    if (wr_sync) begin
      inversion_sync_select_next = inversion_field;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      inversion_sync_select_reg <= RESET_SYNC_CONFIGURATION[INVERSION_SYNC_BIT];
    end else begin
      inversion_sync_select_reg <= inversion_sync_select_next;
    end
  end

  always_comb begin
    force_sync_select_next = force_sync_select_reg;
    if (wr_sync) begin
      force_sync_select_next = force_sync_field;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      force_sync_select_reg <= RESET_SYNC_CONFIGURATION[FORCE_SYNC_BIT];
    end else begin
      force_sync_select_reg <= force_sync_select_next;
    end
  end

  // Pair m covers channels 2m and 2m+1; forcing follows the swap, so a forced pin ignores inversion.
  genvar g;
  generate
    for (g = 0; g < NUM_CHANNELS; g++) begin : g_chan
      localparam int PAIR = g / 2;
      localparam int PARTNER = g ^ 1;
      logic own_level;
      logic partner_level;
      logic swap_on;
      logic force_on;
      logic force_level;
      assign own_level = raw_channel_out[g];
      assign partner_level = raw_channel_out[PARTNER];
      assign swap_on = swap_active_reg[PAIR];
      assign force_on = force_active_reg.enable[g];
      assign force_level = force_active_reg.value[g];
      assign swapped[g] = swap_on ? partner_level : own_level;
      assign forced[g] = force_on ? force_level : swapped[g];
    end
  endgenerate

  // The pins come from flip-flops so that no glitch of the select logic reaches a load.
  always_comb begin
    pin_next = forced;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= pin_next;
    end
  end
endmodule
`default_nettype wire

// >>> pof_pkg.sv
// Package for the PWM output swap and software force stage.
`default_nettype none
package pof_pkg;
  localparam int CHANNELS = 8;
  localparam int PAIRS = 4;
  localparam logic [7:0] OFS_SOFTWARE_OUTPUT_FORCE = 8'h94;
  localparam logic [7:0] OFS_PAIR_SWAP_CONTROL = 8'h90;
  localparam logic [7:0] OFS_SYNC_CONFIGURATION = 8'h8c;
  localparam int FORCE_VALUE_LSB = 8;
  localparam int FORCE_ENABLE_LSB = 0;
  localparam int INVERSION_SYNC_BIT = 4;
  localparam int FORCE_SYNC_BIT = 5;
  localparam logic [31:0] RESET_SOFTWARE_OUTPUT_FORCE = 32'h0000_0000;
  localparam logic [31:0] RESET_PAIR_SWAP_CONTROL = 32'h0000_0000;
  localparam logic [31:0] RESET_SYNC_CONFIGURATION = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_READ_VALUE = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] value;
    logic [7:0] enable;
  } pof_force_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
  } pof_bus_req_t;
endpackage
`default_nettype wire

// >>> pof_output_stage_props.sv
// Checker for bus timing, zero fields and pin release of the output stage.
`default_nettype none
module pof_output_stage_chk
  import pof_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic swap_sync_event,
  input wire logic force_sync_event,
  input wire logic [7:0] avs_address,
  input wire logic [31:0] avs_readdata,
  input wire logic [NUM_CHANNELS-1:0] raw_channel_out,
  input wire logic [NUM_CHANNELS-1:0] channel_pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic rq = avs_read | avs_write;
  wire logic rd = avs_read & ~avs_waitrequest;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_ws; $rose(rq) |-> avs_waitrequest; endproperty
  a_ws: assert property (p_ws) else $error("no wait");
  property p_we; avs_waitrequest |=> !avs_waitrequest; endproperty
  a_we: assert property (p_we) else $error("long wait");
  property p_wq; avs_waitrequest |-> rq; endproperty
  a_wq: assert property (p_wq) else $error("idle wait");
  property p_rs; $changed(avs_readdata) |-> $past(avs_read & avs_waitrequest); endproperty
  a_rs: assert property (p_rs) else $error("data moved");
  property p_sz; rd && avs_address == OFS_PAIR_SWAP_CONTROL |-> avs_readdata[31:4] == 28'h0; endproperty
  a_sz: assert property (p_sz) else $error("swap high bits");
  property p_fz; rd && avs_address == OFS_SOFTWARE_OUTPUT_FORCE |-> avs_readdata[31:16] == 16'h0; endproperty
  a_fz: assert property (p_fz) else $error("force high bits");
  property p_um; rd && avs_address == 8'h40 |-> avs_readdata == UNMAPPED_READ_VALUE; endproperty
  a_um: assert property (p_um) else $error("unmapped data");
  property p_rp; $rose(rst_n) |=> channel_pin_out == $past(raw_channel_out); endproperty
  a_rp: assert property (p_rp) else $error("pins after reset");
  cover property (rd);
  cover property (swap_sync_event);
  cover property (force_sync_event);
endmodule
bind pof_output_stage pof_output_stage_chk #(
  .NUM_CHANNELS(NUM_CHANNELS)
) u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest),
  .swap_sync_event(swap_sync_event),
  .force_sync_event(force_sync_event),
  .avs_address(avs_address),
  .avs_readdata(avs_readdata),
  .raw_channel_out(raw_channel_out),
  .channel_pin_out(channel_pin_out)
);
`default_nettype wire

// >>> pof_pin_load.sv
// External load on the channel pins.
`default_nettype none
module pof_pin_load (
  input wire logic clock,
  input wire logic [7:0] pins,
  output var logic [7:0] level
);
  timeunit 1ns; timeprecision 1ns;
  always_ff @(posedge clock) level <= pins;
endmodule
`default_nettype wire

// >>> tb_pwm_output_invert_and_force.sv
// Self-checking bench for the swap and force stage.
`default_nettype none
module tb_pwm_output_invert_and_force;
  timeunit 1ns; timeprecision 1ns;
  import pof_pkg::*;
  logic clock = 1'b0, rst_n, avs_read, avs_write, avs_waitrequest, swap_sync_event, force_sync_event;
  logic [7:0] avs_address, raw_channel_out, channel_pin_out, load_level;
  logic [31:0] avs_writedata, avs_readdata, q, v;
  logic [3:0] sw;
  logic [15:0] fo;
  int fail_count, cmp_count;
  pof_output_stage DUT (
    .clock(clock),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .swap_sync_event(swap_sync_event),
    .force_sync_event(force_sync_event),
    .raw_channel_out(raw_channel_out),
    .channel_pin_out(channel_pin_out)
  );
  pof_pin_load u_load (.clock, .pins(channel_pin_out), .level(load_level));
  initial forever #5 clock = ~clock;
  initial #100000 report_and_stop(1);
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %0t %h %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop(input int hung);
    fail_count += hung;
    $display("cmp %0d fail %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_read <= ~wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    // Waitrequest and read data are taken at the edge itself, before the design updates them.
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 9);
    if (avs_waitrequest !== 1'b0) begin
      report_and_stop(1);
    end else begin
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  // Reference: swap each enabled pair, then let forced channels override.
  task automatic pin();
    logic [7:0] o;
    logic [7:0] e;
    @(posedge clock);
    raw_channel_out <= 8'($urandom);
    @(posedge clock);
    #1 o = raw_channel_out;
    for (int m = 0; m < PAIRS; m++) if (sw[m]) {o[2*m], o[2*m+1]} = o[2*m+:2];
    e = (o & ~fo[7:0]) | (fo[15:8] & fo[7:0]);
    chk({24'h0, channel_pin_out}, {24'h0, e});
    @(posedge clock);
    #1 chk({24'h0, load_level}, {24'h0, e});
  endtask
  initial begin
    {rst_n, avs_read, avs_write, swap_sync_event, force_sync_event} = 5'h0;
    {avs_address, avs_writedata, fail_count, cmp_count} = '0;
    void'($urandom(58462));
    raw_channel_out = 8'($urandom);
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    rd(OFS_SOFTWARE_OUTPUT_FORCE, RESET_SOFTWARE_OUTPUT_FORCE);
    rd(OFS_PAIR_SWAP_CONTROL, RESET_PAIR_SWAP_CONTROL);
    rd(8'h40, UNMAPPED_READ_VALUE);
    rd(OFS_SYNC_CONFIGURATION, RESET_SYNC_CONFIGURATION);
    repeat (40) begin
      v = $urandom;
      bus(1'b1, OFS_PAIR_SWAP_CONTROL, v);
      sw = v[3:0];
      rd(OFS_PAIR_SWAP_CONTROL, {28'h0, sw});
      v = $urandom;
      bus(1'b1, OFS_SOFTWARE_OUTPUT_FORCE, v);
      fo = v[15:0];
      rd(OFS_SOFTWARE_OUTPUT_FORCE, {16'h0, fo});
      pin();
    end
    // Both sync selects set, so new writes must wait for their own event.
    bus(1'b1, OFS_SYNC_CONFIGURATION, 32'h30);
    rd(OFS_SYNC_CONFIGURATION, 32'h30);
    bus(1'b1, OFS_PAIR_SWAP_CONTROL, {28'h0, ~sw});
    bus(1'b1, OFS_SOFTWARE_OUTPUT_FORCE, {16'h0, ~fo});
    pin();
    @(posedge clock) swap_sync_event <= 1'b1;
    @(posedge clock) swap_sync_event <= 1'b0;
    sw = ~sw;
    pin();
    @(posedge clock) force_sync_event <= 1'b1;
    @(posedge clock) force_sync_event <= 1'b0;
    fo = ~fo;
    pin();
    report_and_stop(0);
  end
endmodule
`default_nettype wire
